// File: core/ues_defines.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          USB error and transfer status block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef UES_DEFINES_SVH
`define UES_DEFINES_SVH

// Register byte offsets
`define UES_OFF_ERR_FLAGS 12'h000
`define UES_OFF_ERR_EN 12'h004
`define UES_OFF_TRN_STAT 12'h008
`define UES_OFF_INT_FLAGS 12'h00C
`define UES_OFF_INT_EN 12'h010
`define UES_OFF_CTRL 12'h014

// Error flag bit positions
`define UES_BIT_STUFF 7
`define UES_BIT_BADADDR 6
`define UES_BIT_MEMFAULT 5
`define UES_BIT_TURNAROUND 4
`define UES_BIT_PARTIAL 3
`define UES_BIT_CRC16 2
`define UES_BIT_SHARED1 1
`define UES_BIT_PID 0

// Main interrupt and control bit positions
`define UES_BIT_TOKDONE 3
`define UES_BIT_ERRSUM 1
`define UES_BIT_HOST_CAPABILITY_ENABLE 3

// Reset values
`define UES_RST_BYTE 8'h00

// Turnaround limit in bit times, and status FIFO depth
`define UES_TURN_BITS 16
`define UES_FIFO_DEPTH 4

`endif

// File: core/ues_pkg.sv
// Purpose: Shared types for the USB error and transfer status block.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds types only; constants live in the defines header.
package ues_pkg;

  // One status FIFO entry: endpoint, direction, bank
  typedef struct packed {
    logic [3:0] endpoint;
    logic dirTx;
    logic oddBank;
  } ues_entry_s;

  // Turnaround watchdog states
  typedef enum logic [1:0] {
    UES_TW_IDLE = 2'b00,
    UES_TW_WAIT = 2'b01,
    UES_TW_DONE = 2'b10
  } ues_tw_e;

endpackage

// File: core/ues_stat_fifo.sv
// Purpose: Small FIFO of completed transaction entries.
// Assumes: Push and pop on the same clock; pop of empty is ignored.
// Notes:   Push into a full FIFO is dropped unless a pop comes in the same cycle; head shows when non-empty.
`timescale 1ns/10ps
`default_nettype none
module ues_stat_fifo #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Write side
  input wire logic push,
  input wire ues_pkg::ues_entry_s pushData,
  output logic full,
  // Read side
  input wire logic pop,
  output ues_pkg::ues_entry_s head,
  output logic empty
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("ues_stat_fifo: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    ues_pkg::ues_entry_s [DEPTH-1:0] mem;
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] wrPtr;
    logic [AW:0] count;
  } ues_fifo_s;

  ues_fifo_s st;
  ues_fifo_s next_st;
  logic doPush;
  logic doPop;

  // Pointer and storage update
  always_comb begin
    next_st = st;
    doPop = pop && (st.count != '0);
    doPush = push && (st.count != (AW+1)'(DEPTH) || doPop);
    if (doPush) begin
      next_st.mem[st.wrPtr] = pushData;
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (doPop) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    if (doPush && !doPop) begin
      next_st.count = st.count + 1'b1;
    end else if (doPop && !doPush) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Status outputs
  assign head = st.mem[st.rdPtr];
  assign empty = (st.count == '0);
  assign full = (st.count == (AW+1)'(DEPTH));

endmodule
`default_nettype wire

// File: core/ues_turn_timer.sv
// Purpose: Bus turnaround watchdog counting idle bit times after an EOP.
// Assumes: bitTick pulses once per full-speed bit time, same clock.
// Notes:   Fires once when idle passes the limit with no response seen.
`timescale 1ns/10ps
`default_nettype none
`include "ues_defines.svh"
module ues_turn_timer #(
  parameter int LIMIT = `UES_TURN_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link events
  input wire logic bitTick,
  input wire logic eopSeen,
  input wire logic respStart,
  input wire logic expectResp,
  // Result
  output logic timeout
);

  initial begin
    if (LIMIT < 1 || LIMIT > 254) begin
      $error("ues_turn_timer: LIMIT out of range");
    end
  end

  typedef struct packed {
    ues_pkg::ues_tw_e mode;
    logic [7:0] bits;
    logic fire;
  } ues_tw_s;

  ues_tw_s st;
  ues_tw_s next_st;

  // Count idle bit times; fire on passing the limit
  always_comb begin
    next_st = st;
    next_st.fire = 1'b0;
    unique case (st.mode)
      ues_pkg::UES_TW_IDLE: begin
        if (eopSeen && expectResp) begin
          next_st.mode = ues_pkg::UES_TW_WAIT;
          next_st.bits = '0;
        end
      end
      ues_pkg::UES_TW_WAIT: begin
        if (respStart) begin
          next_st.mode = ues_pkg::UES_TW_IDLE;
        end else if (bitTick) begin
          next_st.bits = st.bits + 8'h01;
          if (st.bits == 8'(LIMIT)) begin
            next_st.fire = 1'b1;
            next_st.mode = ues_pkg::UES_TW_DONE;
          end
        end
      end
      ues_pkg::UES_TW_DONE: begin
        next_st.mode = ues_pkg::UES_TW_IDLE;
      end
      default: begin
        next_st.mode = ues_pkg::UES_TW_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{mode: ues_pkg::UES_TW_IDLE, bits: 8'h00, fire: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign timeout = st.fire;

endmodule
`default_nettype wire

// File: core/ues_status.sv
// Purpose: USB error flags, error enables, error summary and the
//          transaction status FIFO, reached over APB.
// Assumes: Link and memory-side events are single-cycle pulses on clk.
// Notes:   Unmapped addresses read zero and answer with pslverr.
// Contract
// - Bit-stuff violation sets bit 7 flag
// - Invalid table or buffer address sets bit 6
// - Memory grant late or truncation sets bit 5
// - Over 16 idle bit times sets bit 4
// - Non-whole byte data field sets bit 3
// - Data CRC16 mismatch sets bit 2
// - Function mode: bit 1 is token CRC5
// - Host mode: bit 1 is frame-end overrun
// - PID complement failure sets bit 0
// - Flags hardware-set, reset zero, write-one clears
// - Enables per flag, reset zero, gate interrupt
// - Error reaches combined interrupt only if enabled
// - Bits 7-4 give last endpoint number
// - Bit 3 one for transmit, zero receive
// - Bit 2 one for odd bank
// - Status shows four-entry FIFO head, bits 1-0 zero
// - Clearing token-complete pops the status FIFO
// - Bits 31-8 of all three read zero
// - Token finish sets token-complete flag
// - Error summary set only by enabled errors
// - Host enable selects meaning of bit 1
`timescale 1ns/10ps
`default_nettype none
`include "ues_defines.svh"
module ues_status #(
  parameter int FIFO_DEPTH = `UES_FIFO_DEPTH,
  parameter int TURN_BITS = `UES_TURN_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link error events
  input wire logic stuffErr,
  input wire logic badAddr,
  input wire logic memFault,
  input wire logic partialByte,
  input wire logic crc16Err,
  input wire logic crc5Err,
  input wire logic pidErr,
  // Host frame events
  input wire logic xferActive,
  input wire logic frameCountZero,
  // Turnaround watch events
  input wire logic bitTick,
  input wire logic eopSeen,
  input wire logic respStart,
  input wire logic expectResp,
  // Token completion
  input wire logic tokenDone,
  input wire logic [3:0] doneEndpoint,
  input wire logic doneDirTx,
  input wire logic doneOddBank,
  // Interrupt and mode outputs
  output logic combinedUsbInterrupt,
  output logic hostCapabilityEnable,
  output logic fifoOverflow
);

  initial begin
    if (TURN_BITS < 1 || TURN_BITS > 254) begin
      $error("ues_status: TURN_BITS out of range");
    end
  end

  typedef struct packed {
    logic [7:0] errFlags;
    logic [7:0] errEn;
    logic tokenFlag;
    logic errSumFlag;
    logic tokenEn;
    logic errSumEn;
    logic host_capability_enable;
    logic overflow;
    logic [31:0] rdata;
    logic slvErr;
  } ues_st_s;

  ues_st_s st;
  ues_st_s next_st;

  logic turnTimeout;
  logic fifoFull;
  logic fifoEmpty;
  logic fifoPop;
  logic fifoPush;
  ues_pkg::ues_entry_s fifoHead;
  ues_pkg::ues_entry_s pushEntry;
  logic [7:0] hwSet;
  logic [7:0] w1c;
  logic [7:0] intW1c;
  logic wrAcc;
  logic rdAcc;
  logic errHit;

  // Turnaround watchdog
  ues_turn_timer #(
    .LIMIT(TURN_BITS)
  ) uTurn (
    .clk(clk),
    .nrst(nrst),
    .bitTick(bitTick),
    .eopSeen(eopSeen),
    .respStart(respStart),
    .expectResp(expectResp),
    .timeout(turnTimeout)
  );

  // Completed transaction FIFO
  ues_stat_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .nrst(nrst),
    .push(fifoPush),
    .pushData(pushEntry),
    .full(fifoFull),
    .pop(fifoPop),
    .head(fifoHead),
    .empty(fifoEmpty)
  );

  // Byte-lane masked write-one-clear of the low byte
  function automatic logic [7:0] low_w1c(input logic hit,
                                         input logic [3:0] strb,
                                         input logic [31:0] data);
    low_w1c = (hit && strb[0]) ? data[7:0] : 8'h00;
  endfunction

  // APB access qualifiers; slave answers with zero wait states
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && !penable && !pwrite;
  assign w1c = low_w1c(wrAcc && paddr == `UES_OFF_ERR_FLAGS, pstrb, pwdata);
  assign intW1c = low_w1c(wrAcc && paddr == `UES_OFF_INT_FLAGS, pstrb,
                          pwdata);

  // Hardware error sources
  always_comb begin
    hwSet = 8'h00;
    hwSet[`UES_BIT_STUFF] = stuffErr;
    hwSet[`UES_BIT_BADADDR] = badAddr;
    hwSet[`UES_BIT_MEMFAULT] = memFault;
    hwSet[`UES_BIT_TURNAROUND] = turnTimeout;
    hwSet[`UES_BIT_PARTIAL] = partialByte;
    hwSet[`UES_BIT_CRC16] = crc16Err;
    hwSet[`UES_BIT_SHARED1] = st.host_capability_enable ? (xferActive && frameCountZero)
                                        : crc5Err;
    hwSet[`UES_BIT_PID] = pidErr;
  end

  // Any enabled error this cycle, feeds the summary flag
  assign errHit = |(hwSet & st.errEn);

  // Status FIFO entry and handshake
  assign pushEntry = '{endpoint: doneEndpoint, dirTx: doneDirTx,
                       oddBank: doneOddBank};
  assign fifoPush = tokenDone;
  assign fifoPop = st.tokenFlag && intW1c[`UES_BIT_TOKDONE];

  // Register next-state logic
  always_comb begin
    next_st = st;
    next_st.errFlags = (st.errFlags & ~w1c) | hwSet;
    next_st.tokenFlag = (!fifoEmpty && !fifoPop) ||
                        (fifoPop && tokenDone);
    next_st.errSumFlag = (st.errSumFlag && !intW1c[`UES_BIT_ERRSUM]) ||
                         errHit;
    next_st.overflow = st.overflow || (tokenDone && fifoFull && !fifoPop);
    if (wrAcc && pstrb[0]) begin
      unique case (paddr)
        `UES_OFF_ERR_EN: begin
          next_st.errEn = pwdata[7:0];
        end
        `UES_OFF_INT_EN: begin
          next_st.tokenEn = pwdata[`UES_BIT_TOKDONE];
          next_st.errSumEn = pwdata[`UES_BIT_ERRSUM];
        end
        `UES_OFF_CTRL: begin
          next_st.host_capability_enable = pwdata[`UES_BIT_HOST_CAPABILITY_ENABLE];
        end
        default: begin
          next_st.errEn = st.errEn;
        end
      endcase
    end
    next_st.slvErr = 1'b0;
    if (rdAcc || (psel && !penable && pwrite)) begin
      next_st.rdata = 32'h0000_0000;
      next_st.slvErr = 1'b0;
      unique case (paddr)
        `UES_OFF_ERR_FLAGS: next_st.rdata[7:0] = st.errFlags;
        `UES_OFF_ERR_EN: next_st.rdata[7:0] = st.errEn;
        `UES_OFF_TRN_STAT: next_st.rdata[7:0] = {fifoHead, 2'b00};
        `UES_OFF_INT_FLAGS: begin
          next_st.rdata[`UES_BIT_TOKDONE] = st.tokenFlag;
          next_st.rdata[`UES_BIT_ERRSUM] = st.errSumFlag;
        end
        `UES_OFF_INT_EN: begin
          next_st.rdata[`UES_BIT_TOKDONE] = st.tokenEn;
          next_st.rdata[`UES_BIT_ERRSUM] = st.errSumEn;
        end
        `UES_OFF_CTRL: next_st.rdata[`UES_BIT_HOST_CAPABILITY_ENABLE] = st.host_capability_enable;
        default: next_st.slvErr = 1'b1;
      endcase
      if (!rdAcc) begin
        next_st.rdata = 32'h0000_0000;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // APB answer, zero wait states
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.slvErr && psel && penable;

  assign combinedUsbInterrupt = (st.errSumFlag && st.errSumEn) ||
                                (st.tokenFlag && st.tokenEn);
  assign hostCapabilityEnable = st.host_capability_enable;
  assign fifoOverflow = st.overflow;

  // Assertions
  property p_stuff_sets;
    @(posedge clk) disable iff (!nrst)
      stuffErr |=> st.errFlags[`UES_BIT_STUFF];
  endproperty
  a_stuff_sets: assert property (p_stuff_sets)
    else $error("stuff flag not set");

  property p_pid_sets;
    @(posedge clk) disable iff (!nrst)
      pidErr |=> st.errFlags[`UES_BIT_PID];
  endproperty
  a_pid_sets: assert property (p_pid_sets)
    else $error("pid flag not set");

  property p_flag_hold;
    @(posedge clk) disable iff (!nrst)
      (st.errFlags[`UES_BIT_CRC16] && !w1c[`UES_BIT_CRC16])
        |=> st.errFlags[`UES_BIT_CRC16];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without clear");

  property p_clear;
    @(posedge clk) disable iff (!nrst)
      (w1c[`UES_BIT_PARTIAL] && !partialByte)
        |=> !st.errFlags[`UES_BIT_PARTIAL];
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared");

  property p_host_bit1;
    @(posedge clk) disable iff (!nrst)
      (st.host_capability_enable && crc5Err && !(xferActive && frameCountZero) &&
       !st.errFlags[`UES_BIT_SHARED1]) |=> !st.errFlags[`UES_BIT_SHARED1];
  endproperty
  a_host_bit1: assert property (p_host_bit1)
    else $error("crc5 set flag in host mode");

  property p_sum_enabled;
    @(posedge clk) disable iff (!nrst)
      $rose(st.errSumFlag) |-> $past(errHit);
  endproperty
  a_sum_enabled: assert property (p_sum_enabled)
    else $error("summary set by masked error");

  property p_irq_gate;
    @(posedge clk) disable iff (!nrst)
      (!st.errSumEn && !st.tokenEn) |-> !combinedUsbInterrupt;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enable");

  sequence s_done_into_empty;
    fifoEmpty && tokenDone;
  endsequence
  property p_token_set;
    @(posedge clk) disable iff (!nrst)
      s_done_into_empty |=> ##1 st.tokenFlag;
  endproperty
  a_token_set: assert property (p_token_set)
    else $error("token flag not set");

  property p_badaddr_sets;
    @(posedge clk) disable iff (!nrst)
      badAddr |=> st.errFlags[`UES_BIT_BADADDR];
  endproperty
  a_badaddr_sets: assert property (p_badaddr_sets)
    else $error("bad address flag not set");

  property p_frame_end;
    @(posedge clk) disable iff (!nrst)
      (st.host_capability_enable && xferActive && frameCountZero)
        |=> st.errFlags[`UES_BIT_SHARED1];
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("frame end flag not set");

  property p_en_hold;
    @(posedge clk) disable iff (!nrst)
      !(wrAcc && pstrb[0] && paddr == `UES_OFF_ERR_EN) |=> $stable(st.errEn);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("enables changed without write");

  property p_upper_zero;
    @(posedge clk) disable iff (!nrst)
      (psel && penable && !pwrite) |-> (prdata[31:8] == 24'h00_0000);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");

  sequence s_clear_full;
    st.tokenFlag && intW1c[`UES_BIT_TOKDONE] && fifoFull && !tokenDone;
  endsequence
  property p_pop_frees;
    @(posedge clk) disable iff (!nrst)
      s_clear_full |=> !fifoFull;
  endproperty
  a_pop_frees: assert property (p_pop_frees)
    else $error("token clear did not pop");

endmodule
`default_nettype wire

// File: verif/ues_link_model.sv
// Purpose: Far-side model of the link and memory-side event sources.
// Assumes: Every event is launched just after a rising edge of clk.
// Notes:   Entry lines show the inverse of the last entry between pulses.
`timescale 1ns/10ps
`default_nettype none
module ues_link_model (
  // Clock
  input wire logic clk,
  // Error events, indexed by flag bit position
  output logic [7:0] errPulse,
  // Host frame and turnaround events
  output logic xferActive,
  output logic frameCountZero,
  output logic bitTick,
  output logic eopSeen,
  output logic respStart,
  output logic expectResp,
  // Token completion, endpoint then direction then bank
  output logic tokenDone,
  output logic [5:0] doneInfo
);
  // Quiet lines at time zero
  initial begin
    errPulse = 8'h00;
    {xferActive, frameCountZero, bitTick} = 3'b000;
    {eopSeen, respStart, expectResp, tokenDone} = 4'b0000;
    doneInfo = 6'h15;
  end

  // One-cycle error pulse on one flag position
  task automatic pulseErr(input int b);
    @(posedge clk);
    errPulse[b] <= 1'b1;
    @(posedge clk);
    errPulse[b] <= 1'b0;
  endtask

  // Frame countdown expires, with or without a transfer running
  task automatic frameEnd(input logic act, input logic zero);
    @(posedge clk);
    xferActive <= act;
    frameCountZero <= zero;
    @(posedge clk);
    xferActive <= 1'b0;
    frameCountZero <= 1'b0;
  endtask

  // End of packet, answer expected or not
  task automatic eop(input logic exp);
    @(posedge clk);
    eopSeen <= 1'b1;
    expectResp <= exp;
    @(posedge clk);
    eopSeen <= 1'b0;
    expectResp <= 1'b0;
  endtask

  // Answer starts on the bus
  task automatic respond();
    @(posedge clk);
    respStart <= 1'b1;
    @(posedge clk);
    respStart <= 1'b0;
  endtask

  // Idle bit times, one tick every other cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      bitTick <= 1'b1;
      @(posedge clk);
      bitTick <= 1'b0;
    end
  endtask

  // Completed transaction, entry valid only with the pulse
  task automatic complete(input logic [5:0] info);
    @(posedge clk);
    tokenDone <= 1'b1;
    doneInfo <= info;
    @(posedge clk);
    tokenDone <= 1'b0;
    doneInfo <= ~info;
  endtask
endmodule
`default_nettype wire

// File: verif/test_ues_status.sv
// Purpose: Self-checking bench for the error and status register block.
// Assumes: APB slave answers when pready is high; link model drives events.
// Notes:   Expectations come from bit positions and register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ues_defines.svh"
module test_ues_status;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, slvErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic intr, host_capability_enable, fifoOvf, xferActive, frameCountZero, bitTick;
  logic eopSeen, respStart, expectResp, tokenDone;
  logic [7:0] errPulse;
  logic [5:0] doneInfo;
  logic [5:0] ent [5];
  int err_total, num_checks, cycles, i;

  // Design and link model
  ues_status #(.FIFO_DEPTH(4), .TURN_BITS(16)) dut_u (.clk(clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stuffErr(errPulse[7]),
    .badAddr(errPulse[6]), .memFault(errPulse[5]),
    .partialByte(errPulse[3]), .crc16Err(errPulse[2]),
    .crc5Err(errPulse[1]), .pidErr(errPulse[0]), .xferActive(xferActive),
    .frameCountZero(frameCountZero), .bitTick(bitTick),
    .eopSeen(eopSeen), .respStart(respStart), .expectResp(expectResp),
    .tokenDone(tokenDone), .doneEndpoint(doneInfo[5:2]),
    .doneDirTx(doneInfo[1]), .doneOddBank(doneInfo[0]),
    .combinedUsbInterrupt(intr), .hostCapabilityEnable(host_capability_enable),
    .fifoOverflow(fifoOvf));
  ues_link_model link_u (.clk(clk), .errPulse(errPulse),
    .xferActive(xferActive), .frameCountZero(frameCountZero),
    .bitTick(bitTick), .eopSeen(eopSeen), .respStart(respStart),
    .expectResp(expectResp), .tokenDone(tokenDone), .doneInfo(doneInfo));

  // Compare and count
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end

  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite} = 4'b0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    ent = '{6'h3F, 6'h00, 6'h29, 6'h16, 6'h33};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // Reset values of the three registers
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      check("reset", rd, 32'h0000_0000);
    end
    apb(1'b1, `UES_OFF_ERR_EN, 32'hFFFF_FFFF);
    apb(1'b0, `UES_OFF_ERR_EN, 32'h0000_0000);
    check("enables", rd, 32'h0000_00FF);
    apb(1'b1, `UES_OFF_ERR_EN, 32'h0000_0000);
    pstrb <= 4'hE;
    apb(1'b1, `UES_OFF_ERR_EN, 32'h0000_00FF);
    pstrb <= 4'hF;
    apb(1'b0, `UES_OFF_ERR_EN, 32'h0000_0000);
    check("strobe", rd, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check("unmapped", {slvErr, rd[30:0]}, 32'h8000_0000);
    // Each event but turnaround sets its own flag; writes with a zero in that bit keep it
    for (i = 0; i < 8; i++) if (i != 4) begin
      link_u.pulseErr(i);
      apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
      check("set", rd, 32'h0000_0001 << i);
      apb(1'b1, `UES_OFF_ERR_FLAGS, ~(32'h0000_0001 << i));
      apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
      check("kept", rd, 32'h0000_0001 << i);
      apb(1'b1, `UES_OFF_ERR_FLAGS, 32'h0000_0001 << i);
      apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
      check("cleared", rd, 32'h0000_0000);
    end
    // Frame-end error only counts in host mode
    link_u.frameEnd(1'b1, 1'b1);
    apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
    check("dev frame", rd, 32'h0000_0000);
    apb(1'b1, `UES_OFF_CTRL, 32'h0000_0008);
    @(negedge clk);
    check("host", {31'h0, host_capability_enable}, 32'h0000_0001);
    link_u.pulseErr(1);
    apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
    check("host crc5", rd, 32'h0000_0000);
    link_u.frameEnd(1'b0, 1'b1);
    apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
    check("idle frame", rd, 32'h0000_0000);
    link_u.frameEnd(1'b1, 1'b1);
    apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
    check("host frame", rd, 32'h0000_0002);
    apb(1'b1, `UES_OFF_ERR_FLAGS, 32'h0000_0002);
    apb(1'b1, `UES_OFF_CTRL, 32'h0000_0000);
    // Turnaround: 16 idle bit times pass, the 17th fires
    link_u.eop(1'b1);
    link_u.ticks(16);
    apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
    check("turn 16", rd, 32'h0000_0000);
    link_u.ticks(1);
    apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
    check("turn 17", rd, 32'h0000_0010);
    apb(1'b1, `UES_OFF_ERR_FLAGS, 32'h0000_0010);
    link_u.eop(1'b1);
    link_u.ticks(4);
    link_u.respond();
    link_u.ticks(20);
    apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
    check("answered", rd, 32'h0000_0000);
    link_u.eop(1'b0);
    link_u.ticks(17);
    apb(1'b0, `UES_OFF_ERR_FLAGS, 32'h0000_0000);
    check("no answer due", rd, 32'h0000_0000);
    // Masked error stays out of the summary and interrupt
    link_u.pulseErr(0);
    apb(1'b0, `UES_OFF_INT_FLAGS, 32'h0000_0000);
    check("masked", {rd[31:1], intr}, 32'h0000_0000);
    apb(1'b1, `UES_OFF_ERR_FLAGS, 32'h0000_0001);
    apb(1'b1, `UES_OFF_ERR_EN, 32'h0000_0001);
    link_u.pulseErr(0);
    apb(1'b0, `UES_OFF_INT_FLAGS, 32'h0000_0000);
    check("summary", {rd[31:1], intr}, 32'h0000_0002);
    apb(1'b1, `UES_OFF_INT_EN, 32'h0000_0002);
    @(negedge clk);
    check("intr on", {31'h0, intr}, 32'h0000_0001);
    apb(1'b1, `UES_OFF_INT_EN, 32'h0000_0000);
    apb(1'b1, `UES_OFF_ERR_EN, 32'h0000_0000);
    apb(1'b1, `UES_OFF_ERR_FLAGS, 32'h0000_0001);
    apb(1'b1, `UES_OFF_INT_FLAGS, 32'h0000_0002);
    @(negedge clk);
    check("intr off", {31'h0, intr}, 32'h0000_0000);
    // Five completions into a four-entry queue
    for (i = 0; i < 5; i++) link_u.complete(ent[i]);
    repeat (2) @(posedge clk);
    check("overflow", {31'h0, fifoOvf}, 32'h0000_0001);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, `UES_OFF_INT_FLAGS, 32'h0000_0000);
      check("token", rd, 32'h0000_0008);
      apb(1'b0, `UES_OFF_TRN_STAT, 32'h0000_0000);
      check("status", rd, {24'h0, ent[i], 2'b00});
      apb(1'b1, `UES_OFF_INT_FLAGS, 32'h0000_0008);
    end
    apb(1'b0, `UES_OFF_INT_FLAGS, 32'h0000_0000);
    check("drained", rd, 32'h0000_0000);
    results();
  end
endmodule
`default_nettype wire
